// File: bench/ctpwm_load.sv
// load on the pwm pin that times each level of the waveform
`timescale 1ns/10ps

module ctpwm_load (
	input  logic        mclk,
	input  logic        rst_n,
	input  logic        pwm_output_pin,
	output logic [15:0] edges,
	output logic [31:0] seg_a,
	output logic [31:0] seg_b
);
	logic        last;
	logic [31:0] span;

	// count pin changes and keep the two latest level spans in cycles
	always @(posedge mclk) begin
		if (!rst_n) begin
			{last, edges, span, seg_a, seg_b} <= {1'b1, 16'h0, 32'h1, 64'h0};
		end else if (pwm_output_pin != last) begin
			last <= pwm_output_pin;
			edges <= edges + 16'h1;
			seg_a <= span;
			seg_b <= seg_a;
			span <= 32'h1;
		end else begin
			span <= span + 32'h1;
		end
	end
endmodule // ctpwm_load

// File: bench/ctpwm_timer_checker.sv
// port level assertions of the compare pwm timer
`timescale 1ns/10ps
`include "ctpwm_map.vh"

module ctpwm_timer_checker (
	input logic                     mclk,
	input logic                     rst_n,
	input logic                     psel,
	input logic                     penable,
	input logic                     pwrite,
	input logic [`CTPWM_ADDR_W-1:0] paddr,
	input logic [31:0]              pwdata,
	input logic [3:0]               pstrb,
	input logic [31:0]              prdata,
	input logic                     pready,
	input logic                     pslverr,
	input logic                     pwm_output_pin,
	input logic                     timer_irq
);
	logic       wr, run, ressel, connect, init, ien, ctrl_seen, mapped, sh_hit;
	logic [1:0] steady, per_hi, cmp_hi;
	logic [7:0] per_lo, cmp_lo, sh_val;

	assign wr = psel & penable & pwrite & pready & pstrb[0];
	// -------------------------------------------------------------
	// address decode and shadow readback value
	// -------------------------------------------------------------
	always @* begin
		mapped = 1'b1;
		sh_hit = 1'b1;
		sh_val = 8'h00;
		case (paddr)
		`CTPWM_ADDR_PER_LO: sh_val = per_lo;
		`CTPWM_ADDR_PER_HI: sh_val = {6'h00, per_hi};
		`CTPWM_ADDR_CMP_LO: sh_val = cmp_lo;
		`CTPWM_ADDR_CMP_HI: sh_val = {6'h00, cmp_hi};
		`CTPWM_ADDR_CTRL, `CTPWM_ADDR_INIT, `CTPWM_ADDR_IEN: sh_hit = 1'b0;
		default: begin
			sh_hit = 1'b0;
			mapped = 1'b0;
		end
		endcase
	end
	// mirror of the software written bits; steady counts cycles since a mode change
	always @(posedge mclk) begin
		if (!rst_n) begin
			{run, ressel, connect, init, ien, ctrl_seen} <= 6'b010100;
			{steady, per_hi, cmp_hi, per_lo, cmp_lo} <= 22'h0;
		end else begin
			steady <= (steady == 2'h3) ? steady : steady + 2'h1;
			if (wr) begin
				case (paddr)
				`CTPWM_ADDR_CTRL: begin
					{connect, ressel, run} <= {pwdata[6], pwdata[4:3]};
					ctrl_seen <= 1'b1;
					steady <= 2'h0;
				end
				`CTPWM_ADDR_INIT: begin
					init <= pwdata[7];
					steady <= 2'h0;
				end
				`CTPWM_ADDR_IEN: ien <= pwdata[0];
				`CTPWM_ADDR_PER_LO: per_lo <= pwdata[7:0];
				`CTPWM_ADDR_PER_HI: per_hi <= pwdata[1:0];
				`CTPWM_ADDR_CMP_LO: cmp_lo <= pwdata[7:0];
				`CTPWM_ADDR_CMP_HI: cmp_hi <= pwdata[1:0];
				default: ;
				endcase
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_rd_setup;
		psel && !penable && !pwrite;
	endsequence

	a_ready_zero_wait: assert property (s_rd_setup |=> pready) else $error("pready low in access");
	a_slverr_decode: assert property (psel && penable |-> pslverr == !mapped)
		else $error("pslverr disagrees with address decode");
	a_shadow_readback: assert property (s_rd_setup ##0 sh_hit |=> prdata == {24'h0, sh_val})
		else $error("shadow byte readback wrong");
	a_ctrl_reset_value: assert property (s_rd_setup ##0 (paddr == `CTPWM_ADDR_CTRL && !ctrl_seen)
		|=> prdata == 32'h10) else $error("control reset value wrong");
	a_stopped_pin_holds: assert property (steady == 2'h3 && !run && !ressel
		|=> $stable(pwm_output_pin)) else $error("pin moved while stopped");
	a_cleared_init_level: assert property (steady == 2'h3 && ressel && !run
		|-> pwm_output_pin == init) else $error("pin not at initial level in reset");
	a_disconnect_level: assert property (steady == 2'h3 && run && !connect
		|-> pwm_output_pin == init) else $error("disconnected pin not at initial level");
	a_irq_masked_off: assert property (!ien && !$past(ien) |-> !timer_irq)
		else $error("interrupt raised while disabled");
	a_reset_outputs: assert property (disable iff (1'b0) !rst_n
		|=> pwm_output_pin && !timer_irq && prdata == 32'h0) else $error("reset outputs wrong");
endmodule // ctpwm_timer_checker

bind ctpwm_timer ctpwm_timer_checker i_ctpwm_timer_checker (.mclk(mclk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pwm_output_pin(pwm_output_pin), .timer_irq(timer_irq));

// File: bench/ctpwm_timer_test.sv
// self-checking testbench of the compare pwm timer
`timescale 1ns/10ps
`include "ctpwm_map.vh"

module ctpwm_timer_test;
	logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, pin, irq, err, held;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata, seg_a, seg_b;
	logic [3:0]  pstrb;
	logic [15:0] edges, mark;
	int          mismatches, comparisons;

	ctpwm_timer i_ctpwm_timer (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pwm_output_pin(pin), .timer_irq(irq));
	ctpwm_load i_ctpwm_load (.mclk(mclk), .rst_n(rst_n), .pwm_output_pin(pin),
		.edges(edges), .seg_a(seg_a), .seg_b(seg_b));

	// clock of 40 ns
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	// one apb transfer: setup, then access until pready
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
		input logic [3:0] s);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'b1, a, d, 4'hf);
	endtask
	task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 8'h00, 4'hf);
		chk(name, exp, rdata);
	endtask
	// let the pin change four times, then compare a full period and its short part
	task automatic wave_chk(input logic [31:0] sum, input logic [31:0] short_span);
		mark = edges;
		while (16'(edges - mark) < 16'h4) @(posedge mclk);
		chk("period", sum, seg_a + seg_b);
		chk("short span", short_span, (seg_a < seg_b) ? seg_a : seg_b);
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// watchdog against a hung wait
	initial begin
		repeat (60000) @(posedge mclk);
		mismatches++;
		give_verdict();
	end

	// -------------------------------------------------------------
	// test sequence
	// -------------------------------------------------------------
	initial begin
		{mismatches, comparisons} = 0;
		{rst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = 0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		rd_chk("control", `CTPWM_ADDR_CTRL, 32'h10);
		rd_chk("initial level", `CTPWM_ADDR_INIT, 32'h80);
		chk("pin", 32'h1, {31'h0, pin});
		wr(`CTPWM_ADDR_PER_LO, 8'ha5);
		wr(`CTPWM_ADDR_PER_HI, 8'hff);
		xfer(1'b1, `CTPWM_ADDR_PER_LO, 8'h5a, 4'h0);
		rd_chk("period low", `CTPWM_ADDR_PER_LO, 32'ha5);
		rd_chk("period high", `CTPWM_ADDR_PER_HI, 32'h3);
		xfer(1'b0, 12'h0fc, 8'h00, 4'hf);
		chk("unmapped error", 32'h1, {31'h0, err});
		$display("test registers done");
		wr(`CTPWM_ADDR_PER_LO, 8'd9);
		wr(`CTPWM_ADDR_PER_HI, 8'h00);
		wr(`CTPWM_ADDR_CMP_LO, 8'd3);
		wr(`CTPWM_ADDR_CMP_HI, 8'h00);
		wr(`CTPWM_ADDR_CTRL, 8'h68);
		wave_chk(32'd20, 32'd8);
		wr(`CTPWM_ADDR_PER_LO, 8'd19);
		rd_chk("period low", `CTPWM_ADDR_PER_LO, 32'd19);
		rd_chk("compare low", `CTPWM_ADDR_CMP_LO, 32'd3);
		wave_chk(32'd20, 32'd8);
		wr(`CTPWM_ADDR_CTRL, 8'h68);
		wave_chk(32'd40, 32'd8);
		rd_chk("control", `CTPWM_ADDR_CTRL, 32'hc8);
		wr(`CTPWM_ADDR_IEN, 8'h01);
		wave_chk(32'd40, 32'd8);
		chk("irq", 32'h1, {31'h0, irq});
		$display("test shadow transfer done");
		wr(`CTPWM_ADDR_CTRL, 8'hc0);
		@(posedge mclk);
		held = pin;
		repeat (100) @(posedge mclk);
		chk("held pin", {31'h0, held}, {31'h0, pin});
		rd_chk("control", `CTPWM_ADDR_CTRL, 32'hc0);
		wr(`CTPWM_ADDR_CTRL, 8'h40);
		repeat (3) @(posedge mclk);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`CTPWM_ADDR_CTRL, 8'h10);
		repeat (3) @(posedge mclk);
		chk("pin", 32'h1, {31'h0, pin});
		$display("test stop and flag done");
		wr(`CTPWM_ADDR_PER_LO, 8'd3);
		wr(`CTPWM_ADDR_CMP_LO, 8'd1);
		for (int k = 0; k < 8; k++) begin
			wr(`CTPWM_ADDR_CTRL, 8'h68 | 8'(k));
			wave_chk(32'd4 << (k + 1), 32'd2 << (k + 1));
		end
		$display("test prescaler done");
		wr(`CTPWM_ADDR_INIT, 8'h00);
		wr(`CTPWM_ADDR_CTRL, 8'h28);
		repeat (20) @(posedge mclk);
		chk("pin", 32'h0, {31'h0, pin});
		mark = edges;
		repeat (100) @(posedge mclk);
		chk("pin changes", {16'h0, mark}, {16'h0, edges});
		wr(`CTPWM_ADDR_CTRL, 8'h48);
		wave_chk(32'd8, 32'd4);
		wr(`CTPWM_ADDR_CTRL, 8'h58);
		wave_chk(32'd8, 32'd4);
		wr(`CTPWM_ADDR_CTRL, 8'h10);
		repeat (3) @(posedge mclk);
		chk("pin", 32'h0, {31'h0, pin});
		$display("test output modes done");
		give_verdict();
	end
endmodule // ctpwm_timer_test

// File: src/ctpwm_map.vh
// register map, field positions, reset values and counts of the compare pwm timer
`ifndef CTPWM_MAP_VH
`define CTPWM_MAP_VH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define CTPWM_IDX_CTRL      10'h0c1
`define CTPWM_IDX_INIT      10'h0c2
`define CTPWM_IDX_IEN       10'h0c3
`define CTPWM_IDX_PER_LO    10'h0d2
`define CTPWM_IDX_PER_HI    10'h0d3
`define CTPWM_IDX_CMP_LO    10'h0d4
`define CTPWM_IDX_CMP_HI    10'h0d5
`define CTPWM_ADDR_CTRL     {`CTPWM_IDX_CTRL, 2'h0}
`define CTPWM_ADDR_INIT     {`CTPWM_IDX_INIT, 2'h0}
`define CTPWM_ADDR_IEN      {`CTPWM_IDX_IEN, 2'h0}
`define CTPWM_ADDR_PER_LO   {`CTPWM_IDX_PER_LO, 2'h0}
`define CTPWM_ADDR_PER_HI   {`CTPWM_IDX_PER_HI, 2'h0}
`define CTPWM_ADDR_CMP_LO   {`CTPWM_IDX_CMP_LO, 2'h0}
`define CTPWM_ADDR_CMP_HI   {`CTPWM_IDX_CMP_HI, 2'h0}

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define CTPWM_CTRL_FLAG     7
`define CTPWM_CTRL_CONNECT  6
`define CTPWM_CTRL_STE      5
`define CTPWM_CTRL_RESSEL   4
`define CTPWM_CTRL_RUN      3
`define CTPWM_CTRL_PSC_HI   2
`define CTPWM_CTRL_PSC_LO   0
`define CTPWM_CTRL_RESET    8'h10

// ----------------------------------------------------------------------------
// initial level and interrupt enable fields
// ----------------------------------------------------------------------------
`define CTPWM_INIT_LEVEL    7
`define CTPWM_INIT_RESET    8'h80
`define CTPWM_INIT_MASK     8'h80
`define CTPWM_PIN_RESET     1'b1
`define CTPWM_IEN_BIT       0
`define CTPWM_IEN_RESET     8'h00
`define CTPWM_IEN_MASK      8'h01

// ----------------------------------------------------------------------------
// widths and values
// ----------------------------------------------------------------------------
`define CTPWM_CNT_W         10
`define CTPWM_CNT_ZERO      10'h000
`define CTPWM_CNT_ONE       10'h001
`define CTPWM_HI_BITS       2
`define CTPWM_SHADOW_RESET  10'h000
`define CTPWM_PSC_W         8
`define CTPWM_PSC_RESET     8'h00
`define CTPWM_PSC_ONE       8'h01
`define CTPWM_DATA_ZERO     32'h00000000
`define CTPWM_ADDR_W        12
`define CTPWM_WORD_LANE     2'h0

`endif

// File: src/ctpwm_prescaler.v
// prescaler that makes the counting enable pulse of the compare pwm timer
`timescale 1ns/10ps
`include "ctpwm_map.vh"

module ctpwm_prescaler (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire [2:0] prescale_select,
	output wire       count_tick
);

	reg  [`CTPWM_PSC_W-1:0] div_count;
	wire [`CTPWM_PSC_W-1:0] low_mask;

	// ------------------------------------------------------------------------
	// free running divider
	// ------------------------------------------------------------------------
	// mask covers select+1 low bits, so the tick period is 2 to 256 cycles
	assign low_mask = (`CTPWM_PSC_ONE << prescale_select) | ((`CTPWM_PSC_ONE << prescale_select) - `CTPWM_PSC_ONE);

	// divider counts every mclk cycle
	always @(posedge mclk) begin
		if (!rst_n) begin
			div_count <= `CTPWM_PSC_RESET;
		end else begin
			div_count <= div_count + `CTPWM_PSC_ONE;
		end
	end

	// tick when all selected low bits are ones
	assign count_tick = &(div_count | ~low_mask);

endmodule // ctpwm_prescaler

// File: src/ctpwm_shadow.v
// byte writable 10-bit shadow latch for period or compare value
`timescale 1ns/10ps
`include "ctpwm_map.vh"

module ctpwm_shadow (
	input  wire                    mclk,
	input  wire                    rst_n,
	input  wire                    write_low,
	input  wire                    write_high,
	input  wire [7:0]              write_data,
	output reg  [`CTPWM_CNT_W-1:0] shadow_value
);

	// ------------------------------------------------------------------------
	// independent low and high byte writes
	// ------------------------------------------------------------------------
	// each byte keeps its value when the other is written
	always @(posedge mclk) begin
		if (!rst_n) begin
			shadow_value <= `CTPWM_SHADOW_RESET;
		end else begin
			if (write_low) begin
				shadow_value[7:0] <= write_data;
			end
			if (write_high) begin
				shadow_value[`CTPWM_CNT_W-1:8] <= write_data[`CTPWM_HI_BITS-1:0];
			end
		end
	end

endmodule // ctpwm_shadow

// File: src/ctpwm_timer.v
// top of the single channel 10-bit compare pwm timer with its apb register file
`timescale 1ns/10ps
`include "ctpwm_map.vh"

// Functional notes
// - period and compare are 10-bit, byte split, writes go to shadow latches
// - setting control bit 5 arms copy of shadows into working registers
// - armed copy happens only when the counter is at zero next time
// - hardware clears the transfer enable bit with the automatic copy
// - period and compare reads return the shadow latches
// - period flag sets when counter equals working period
// - flag with interrupt enabled raises the timer interrupt request
// - running and not connected, pin shows the initial level bit
// - running and connected, pin shows the generated waveform
// - reset select 0 run 0, counter stops, pin holds its level
// - reset select 0 run 1 runs; first start loads initial level
// - reset select 1 run 0 stops, clears counter, pin takes initial level
// - reset select 1 run 1 keeps running without clearing
// - control register resets to 00010000
// - counter counts zero to working period then back to zero
// - waveform toggles at compare match and again at return to zero
// - prescale select codes divide the clock by 2 up to 256
module ctpwm_timer (
	input  wire                     mclk,
	input  wire                     rst_n,
	input  wire                     psel,
	input  wire                     penable,
	input  wire                     pwrite,
	input  wire [`CTPWM_ADDR_W-1:0] paddr,
	input  wire [31:0]              pwdata,
	input  wire [3:0]               pstrb,
	output reg  [31:0]              prdata,
	output wire                     pready,
	output wire                     pslverr,
	output reg                      pwm_output_pin,
	output reg                      timer_irq
);

	// ------------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------------
	reg  [7:0]              pwm_timer_control;
	reg  [7:0]              initial_level_register;
	reg  [7:0]              pwm_int_enable;
	reg  [`CTPWM_CNT_W-1:0] count_value;
	reg  [`CTPWM_CNT_W-1:0] period_work;
	reg  [`CTPWM_CNT_W-1:0] compare_work;
	reg                     pwm_wave;
	reg                     first_start;
	reg  [7:0]              next_control;
	reg                     next_wave;
	reg  [31:0]             next_rdata;
	wire [`CTPWM_CNT_W-1:0] period_shadow;
	wire [`CTPWM_CNT_W-1:0] compare_shadow;
	wire                    count_tick;
	wire                    setup_phase;
	wire                    write_now;
	wire                    lane0;
	wire                    mapped;
	wire                    period_match_flag;
	wire                    output_connect;
	wire                    shadow_transfer_enable;
	wire                    counter_reset_select;
	wire                    counter_run;
	wire [2:0]              prescale_select;
	wire                    output_initial_level;
	wire                    step;
	wire                    at_period;
	wire                    at_compare;
	wire                    at_zero;
	wire                    transfer_now;
	wire                    start_now;
	wire                    hold_reset;
	wire                    sel_ctrl;
	wire                    sel_init;
	wire                    sel_ien;
	wire                    sel_per_lo;
	wire                    sel_per_hi;
	wire                    sel_cmp_lo;
	wire                    sel_cmp_hi;
	wire                    wr_ctrl;
	wire                    wr_init;
	wire                    wr_ien;
	wire                    wr_per_lo;
	wire                    wr_per_hi;
	wire                    wr_cmp_lo;
	wire                    wr_cmp_hi;

	// ------------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------------
	// compares a bus address against one register word address
	function hit;
		input [`CTPWM_ADDR_W-1:0] addr;
		input [`CTPWM_ADDR_W-1:0] reg_addr;
		begin
			hit = (addr == reg_addr);
		end
	endfunction

	// zero wait state slave, error on unmapped word
	assign pready      = 1'b1;
	assign setup_phase = psel & ~penable;
	assign write_now   = psel & penable & pwrite & pready;
	assign lane0       = pstrb[0];
	assign mapped      = sel_ctrl | sel_init | sel_ien | sel_per_lo | sel_per_hi |
	                     sel_cmp_lo | sel_cmp_hi;
	assign pslverr     = psel & penable & ~mapped;

	// ------------------------------------------------------------------------
	// register selects and write strobes
	// ------------------------------------------------------------------------
	// one select per register word, shared by the write strobes and the error decode; the read path decodes again
	assign sel_ctrl    = hit(paddr, `CTPWM_ADDR_CTRL);
	assign sel_init    = hit(paddr, `CTPWM_ADDR_INIT);
	assign sel_ien     = hit(paddr, `CTPWM_ADDR_IEN);
	assign sel_per_lo  = hit(paddr, `CTPWM_ADDR_PER_LO);
	assign sel_per_hi  = hit(paddr, `CTPWM_ADDR_PER_HI);
	assign sel_cmp_lo  = hit(paddr, `CTPWM_ADDR_CMP_LO);
	assign sel_cmp_hi  = hit(paddr, `CTPWM_ADDR_CMP_HI);

	// a write lands only in the access cycle and only with byte lane 0 on
	assign wr_ctrl     = write_now & lane0 & sel_ctrl;
	assign wr_init     = write_now & lane0 & sel_init;
	assign wr_ien      = write_now & lane0 & sel_ien;
	assign wr_per_lo   = write_now & lane0 & sel_per_lo;
	assign wr_per_hi   = write_now & lane0 & sel_per_hi;
	assign wr_cmp_lo   = write_now & lane0 & sel_cmp_lo;
	assign wr_cmp_hi   = write_now & lane0 & sel_cmp_hi;

	// ------------------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------------------
	assign period_match_flag      = pwm_timer_control[`CTPWM_CTRL_FLAG];
	assign output_connect         = pwm_timer_control[`CTPWM_CTRL_CONNECT];
	assign shadow_transfer_enable = pwm_timer_control[`CTPWM_CTRL_STE];
	assign counter_reset_select   = pwm_timer_control[`CTPWM_CTRL_RESSEL];
	assign counter_run            = pwm_timer_control[`CTPWM_CTRL_RUN];
	assign prescale_select        = pwm_timer_control[`CTPWM_CTRL_PSC_HI:`CTPWM_CTRL_PSC_LO];
	assign output_initial_level   = initial_level_register[`CTPWM_INIT_LEVEL];

	// ------------------------------------------------------------------------
	// prescaler and shadow latches
	// ------------------------------------------------------------------------
	ctpwm_prescaler u_prescaler (
		.mclk            (mclk),
		.rst_n           (rst_n),
		.prescale_select (prescale_select),
		.count_tick      (count_tick)
	);

	// period shadow, written only through the bus
	ctpwm_shadow u_period_shadow (
		.mclk         (mclk),
		.rst_n        (rst_n),
		.write_low    (wr_per_lo),
		.write_high   (wr_per_hi),
		.write_data   (pwdata[7:0]),
		.shadow_value (period_shadow)
	);

	// compare shadow, written only through the bus
	ctpwm_shadow u_compare_shadow (
		.mclk         (mclk),
		.rst_n        (rst_n),
		.write_low    (wr_cmp_lo),
		.write_high   (wr_cmp_hi),
		.write_data   (pwdata[7:0]),
		.shadow_value (compare_shadow)
	);

	// ------------------------------------------------------------------------
	// counter events
	// ------------------------------------------------------------------------
	// counting step only while run is set, whatever reset select says
	assign step         = count_tick & counter_run;
	assign at_period    = (count_value == period_work);
	assign at_compare   = (count_value == compare_work);
	assign at_zero      = (count_value == `CTPWM_CNT_ZERO);
	assign transfer_now = step & at_zero & shadow_transfer_enable;
	assign start_now    = counter_run & first_start;
	assign hold_reset   = counter_reset_select & ~counter_run;

	// ------------------------------------------------------------------------
	// control register next value
	// ------------------------------------------------------------------------
	// hardware set of the flag wins over a software clear in the same cycle
	always @* begin
		next_control = pwm_timer_control;
		if (wr_ctrl) begin
			next_control = pwdata[7:0];
		end
		if (transfer_now & ~(wr_ctrl & pwdata[`CTPWM_CTRL_STE])) begin
			next_control[`CTPWM_CTRL_STE] = 1'b0;
		end
		if (step & at_period) begin
			next_control[`CTPWM_CTRL_FLAG] = 1'b1;
		end
	end

	// control register, software writes steer run, connect and prescale
	always @(posedge mclk) begin
		if (!rst_n) begin
			pwm_timer_control <= `CTPWM_CTRL_RESET;
		end else begin
			pwm_timer_control <= next_control;
		end
	end

	// ------------------------------------------------------------------------
	// initial level and interrupt enable registers
	// ------------------------------------------------------------------------
	always @(posedge mclk) begin
		if (!rst_n) begin
			initial_level_register <= `CTPWM_INIT_RESET;
			pwm_int_enable         <= `CTPWM_IEN_RESET;
		end else begin
			if (wr_init) begin
				initial_level_register <= pwdata[7:0] & `CTPWM_INIT_MASK;
			end
			if (wr_ien) begin
				pwm_int_enable <= pwdata[7:0] & `CTPWM_IEN_MASK;
			end
		end
	end

	// ------------------------------------------------------------------------
	// working registers
	// ------------------------------------------------------------------------
	// loaded from the shadows only on an armed pass through zero
	always @(posedge mclk) begin
		if (!rst_n) begin
			period_work  <= `CTPWM_SHADOW_RESET;
			compare_work <= `CTPWM_SHADOW_RESET;
		end else if (transfer_now) begin
			period_work  <= period_shadow;
			compare_work <= compare_shadow;
		end
	end

	// ------------------------------------------------------------------------
	// compare timer
	// ------------------------------------------------------------------------
	// up count to the working period, then back to zero
	always @(posedge mclk) begin
		if (!rst_n) begin
			count_value <= `CTPWM_CNT_ZERO;
		end else if (hold_reset) begin
			count_value <= `CTPWM_CNT_ZERO;
		end else if (step) begin
			if (at_period) begin
				count_value <= `CTPWM_CNT_ZERO;
			end else begin
				count_value <= count_value + `CTPWM_CNT_ONE;
			end
		end
	end

	// ------------------------------------------------------------------------
	// waveform generation
	// ------------------------------------------------------------------------
	// toggle at compare match and at wrap to zero; both together cancel
	always @* begin
		next_wave = pwm_wave;
		if (hold_reset | start_now) begin
			next_wave = output_initial_level;
		end else if (step) begin
			next_wave = pwm_wave ^ at_compare ^ at_period;
		end
	end

	// waveform state and first start tracking
	always @(posedge mclk) begin
		if (!rst_n) begin
			pwm_wave    <= `CTPWM_PIN_RESET;
			first_start <= 1'b1;
		end else begin
			pwm_wave <= next_wave;
			if (counter_run) begin
				first_start <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// output pin
	// ------------------------------------------------------------------------
	// stopped without reset select keeps the pin as it is
	always @(posedge mclk) begin
		if (!rst_n) begin
			pwm_output_pin <= `CTPWM_PIN_RESET;
		end else if (counter_run) begin
			if (output_connect) begin
				pwm_output_pin <= next_wave;
			end else begin
				pwm_output_pin <= output_initial_level;
			end
		end else if (counter_reset_select) begin
			pwm_output_pin <= output_initial_level;
		end else begin
			pwm_output_pin <= pwm_output_pin;
		end
	end

	// ------------------------------------------------------------------------
	// interrupt request
	// ------------------------------------------------------------------------
	// level request while the flag stands and the enable is set
	always @(posedge mclk) begin
		if (!rst_n) begin
			timer_irq <= 1'b0;
		end else begin
			timer_irq <= next_control[`CTPWM_CTRL_FLAG] & pwm_int_enable[`CTPWM_IEN_BIT];
		end
	end

	// ------------------------------------------------------------------------
	// read data
	// ------------------------------------------------------------------------
	// read path selects the shadow latches, never the working values
	always @* begin
		next_rdata = `CTPWM_DATA_ZERO;
		if (hit(paddr, `CTPWM_ADDR_CTRL)) begin
			next_rdata[7:0] = pwm_timer_control;
		end else if (hit(paddr, `CTPWM_ADDR_INIT)) begin
			next_rdata[7:0] = initial_level_register;
		end else if (hit(paddr, `CTPWM_ADDR_IEN)) begin
			next_rdata[7:0] = pwm_int_enable;
		end else if (hit(paddr, `CTPWM_ADDR_PER_LO)) begin
			next_rdata[7:0] = period_shadow[7:0];
		end else if (hit(paddr, `CTPWM_ADDR_PER_HI)) begin
			next_rdata[`CTPWM_HI_BITS-1:0] = period_shadow[`CTPWM_CNT_W-1:8];
		end else if (hit(paddr, `CTPWM_ADDR_CMP_LO)) begin
			next_rdata[7:0] = compare_shadow[7:0];
		end else if (hit(paddr, `CTPWM_ADDR_CMP_HI)) begin
			next_rdata[`CTPWM_HI_BITS-1:0] = compare_shadow[`CTPWM_CNT_W-1:8];
		end
	end

	// read data is captured in the setup cycle and held through the access
	always @(posedge mclk) begin
		if (!rst_n) begin
			prdata <= `CTPWM_DATA_ZERO;
		end else if (setup_phase & ~pwrite) begin
			prdata <= next_rdata;
		end
	end

endmodule // ctpwm_timer
